// ===== core/swclk_divider.sv
// Purpose: programmable 8 MHz/N oscillator with phase restart
// Assumes: i_tick is a one-cycle 8 MHz pulse
// Notes: output high for the first half of each period
`timescale 1ns/1ns
`default_nettype none
module swclk_divider
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_align,
   input wire logic [5:0] i_n,
   output logic o_clk
);
   logic [5:0] count;
   wire logic wrap = (count >= i_n - 6'h01);

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         count <= 6'h00;
         o_clk <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_align)
         begin
            count <= 6'h00;
            o_clk <= 1'b1;
         end
         else if (i_tick)
         begin
            count <= wrap ? 6'h00 : count + 6'h01;
            o_clk <= wrap || (count + 6'h01 < {1'b0, i_n[5:1]});
         end
      end
   end
endmodule : swclk_divider
`default_nettype wire

// ===== core/swclk_pkg.sv
// Purpose: constants for the switching clock source selector
// Assumes: 50 MHz system clock, strap levels already classified to codes
// Notes: frequencies in the table are held as divider values N of 8 MHz
package swclk_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BASE_HZ = 8_000_000;
   // period of one 8 MHz tick in system clocks, rounded down
   localparam int TICK_CYC = CLK_HZ / BASE_HZ;
   localparam logic [5:0] N_MIN = 6'h08;
   localparam logic [5:0] N_MAX = 6'h28;
   localparam logic [5:0] N_200K = 6'h28;
   localparam logic [5:0] N_400K = 6'h14;
   localparam logic [5:0] N_1M = 6'h08;
   // slowest legal ext clock 200 kHz is 250 clocks; give margin before loss
   localparam int LOSS_CYC = 2 * (CLK_HZ / 200_000);
   localparam int DET_EDGES = 4;
   // register indices
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_FREQ = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   localparam logic [3:0] REG_RDBK = 4'h3;
   // strap level codes
   typedef enum logic [1:0]
   {
      LVL_LOW = 2'h0,
      LVL_OPEN = 2'h1,
      LVL_HIGH = 2'h2,
      LVL_RES = 2'h3
   } level_type;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_SEARCH = 4'b0010,
      ST_LOCKED = 4'b0100,
      ST_INTERNAL = 4'b1000
   } state_type;
endpackage : swclk_pkg

// ===== core/swclk_select.sv
// Purpose: shared switching clock pin role, detection, lock and frequency
// Assumes: strap levels arrive pre-classified; pins synchronous to I_CLK
// Notes: register port is index-addressed, read data one cycle later
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module swclk_select
   import swclk_pkg::*;
#(
   parameter int LOSS_LIMIT = LOSS_CYC
)
(
   // clock, reset, enable
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_CE,
   // straps and resistor code, valid at start-up
   input wire logic [1:0] I_MODE_STRAP,
   input wire logic [1:0] I_PIN_STRAP,
   input wire logic [4:0] I_RES_CODE,
   input wire logic I_STARTUP_DONE,
   // converter enable
   input wire logic I_ENABLE,
   // shared clock pin
   input wire logic I_SYNC_IN,
   output logic O_SYNC_OUT,
   output logic O_SYNC_OE,
   // switching clock to the power stage
   output logic O_SW_CLK,
   output logic O_LOCKED,
   // register port
   input wire logic [3:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA
);
   localparam int PER_W = 12;
   // resistor table as divider values, index 0 is the lowest resistor
   function automatic logic [5:0] res_n(input logic [4:0] code);
      case (code)
         5'h00: res_n = 6'h28;
         5'h01: res_n = 6'h24;
         5'h02: res_n = 6'h21;
         5'h03: res_n = 6'h1e;
         5'h04: res_n = 6'h1b;
         5'h05: res_n = 6'h19;
         5'h06: res_n = 6'h16;
         5'h07: res_n = 6'h14;
         5'h08: res_n = 6'h13;
         5'h09: res_n = 6'h11;
         5'h0a: res_n = 6'h0f;
         5'h0b: res_n = 6'h0e;
         5'h0c: res_n = 6'h0d;
         5'h0d: res_n = 6'h0b;
         5'h0e: res_n = 6'h0a;
         5'h0f: res_n = 6'h09;
         default: res_n = 6'h08;
      endcase
   endfunction : res_n

   // latched straps
   level_type mode;
   level_type pin;
   logic [4:0] res_code;
   logic straps_taken;
   // software frequency
   logic sw_freq_en;
   logic [5:0] sw_n;
   // detection and lock
   state_type state;
   state_type next_state;
   logic enable_d;
   logic sync_d;
   logic [PER_W-1:0] per_count;
   logic [PER_W-1:0] last_period;
   logic [2:0] edge_count;
   logic [5:0] meas_n;
   logic [2:0] tick_count;
   logic [5:0] fb_n;
   logic osc;

   wire logic enable_rise = I_ENABLE && !enable_d;
   wire logic sync_rise = I_SYNC_IN && !sync_d;
   wire logic is_output = (mode == LVL_HIGH);
   wire logic is_auto = (mode == LVL_OPEN);
   wire logic clock_lost = (per_count >= PER_W'(LOSS_LIMIT));
   wire logic tick = (tick_count == 3'(TICK_CYC - 1));
   wire logic detected = sync_rise && (edge_count == 3'(DET_EDGES - 1));
   // period in clocks to N: N = period*8MHz/50MHz, rounded to nearest
   wire logic [PER_W+3:0] scaled = {4'h0, last_period} * 16'h0008
      + 16'h0019;
   wire logic [PER_W+3:0] quot = scaled / 16'h0032;
   wire logic [5:0] quot_n = (quot > 16'(N_MAX)) ? N_MAX :
      (quot < 16'(N_MIN)) ? N_MIN : quot[5:0];
   // requested kHz to N, nearest: (8000 + f/2) / f
   wire logic [15:0] req_khz = (I_WDATA == 16'h0000) ? 16'h0001 : I_WDATA;
   wire logic [15:0] req_q = (16'h1f40 + (req_khz >> 1)) / req_khz;
   wire logic [5:0] req_n = (req_q > 16'(N_MAX)) ? N_MAX :
      (req_q < 16'(N_MIN)) ? N_MIN : req_q[5:0];
   // strap frequency, chosen by the pin strap (resistor code when LVL_RES)
   wire logic [5:0] strap_n =
      (pin == LVL_LOW) ? N_200K :
      (pin == LVL_HIGH) ? N_1M :
      (pin == LVL_RES) ? res_n(res_code) : N_400K;
   wire logic [5:0] free_n = sw_freq_en ? sw_n :
      is_output ? N_400K :
      is_auto ? strap_n : N_400K;
   wire logic [5:0] run_n = (state == ST_INTERNAL) ? fb_n : free_n;
   wire logic align = (state == ST_LOCKED) && sync_rise;
   wire logic [15:0] rd_value =
      (I_ADDR == REG_CTRL) ? {15'h0000, sw_freq_en} :
      (I_ADDR == REG_FREQ) ? {10'h000, sw_n} :
      (I_ADDR == REG_STAT) ? {8'h00, state, mode, pin} :
      (I_ADDR == REG_RDBK) ? {10'h000, run_n} : 16'h0000;

   // straps taken once after start-up, held until I_RESET
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         mode <= LVL_LOW;
         pin <= LVL_OPEN;
         res_code <= 5'h00;
         straps_taken <= 1'b0;
      end
      else if (I_CE && I_STARTUP_DONE && !straps_taken)
      begin
         mode <= level_type'(I_MODE_STRAP);
         pin <= level_type'(I_PIN_STRAP);
         res_code <= I_RES_CODE;
         straps_taken <= 1'b1;
      end
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
            if (enable_rise && straps_taken && !is_output)
               next_state = ST_SEARCH;
         ST_SEARCH:
            if (detected)
               next_state = ST_LOCKED;
            else if (clock_lost)
               next_state = ST_IDLE;
         ST_LOCKED:
            if (clock_lost)
               next_state = ST_INTERNAL;
         ST_INTERNAL:
            if (enable_rise)
               next_state = ST_SEARCH;
      endcase
      if (!I_ENABLE && state == ST_SEARCH)
         next_state = ST_IDLE;
      if (is_output)
         next_state = ST_IDLE;
   end

   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         state <= ST_IDLE;
         enable_d <= 1'b0;
         sync_d <= 1'b0;
         per_count <= '0;
         last_period <= '0;
         edge_count <= 3'h0;
         tick_count <= 3'h0;
         fb_n <= N_400K;
      end
      else if (I_CE)
      begin
         state <= next_state;
         enable_d <= I_ENABLE;
         sync_d <= I_SYNC_IN;
         tick_count <= tick ? 3'h0 : tick_count + 3'h1;
         if (sync_rise || state == ST_IDLE || state == ST_INTERNAL)
            per_count <= '0;
         else if (!clock_lost)
            per_count <= per_count + PER_W'(1);
         if (sync_rise && state != ST_IDLE)
            last_period <= per_count;
         if (state != ST_SEARCH)
            edge_count <= 3'h0;
         else if (sync_rise)
            edge_count <= edge_count + 3'h1;
         if (state == ST_LOCKED && next_state == ST_INTERNAL)
            fb_n <= quot_n;
      end
   end

   // software frequency programming
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         sw_freq_en <= 1'b0;
         sw_n <= N_400K;
      end
      else if (I_CE && I_WR)
      begin
         if (I_ADDR == REG_CTRL)
            sw_freq_en <= I_WDATA[0];
         if (I_ADDR == REG_FREQ)
            sw_n <= req_n;
      end
   end

   swclk_divider u_osc
   (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_ce(I_CE),
      .i_tick(tick),
      .i_align(align),
      .i_n(run_n),
      .o_clk(osc)
   );

   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         O_SYNC_OUT <= 1'b0;
         O_SYNC_OE <= 1'b0;
         O_SW_CLK <= 1'b0;
         O_LOCKED <= 1'b0;
         O_RDATA <= 16'h0000;
      end
      else if (I_CE)
      begin
         O_SYNC_OE <= is_output && straps_taken;
         O_SYNC_OUT <= is_output && osc;
         O_SW_CLK <= (state == ST_LOCKED) ? I_SYNC_IN : osc;
         O_LOCKED <= (state == ST_LOCKED);
         if (I_RD)
            O_RDATA <= rd_value;
      end
   end

   a_output_never_locks: assert property (@(posedge I_CLK)
      disable iff (I_RESET) is_output |=> state == ST_IDLE)
      else $error("output mode entered detection");
   a_enable_starts_search: assert property (@(posedge I_CLK)
      disable iff (I_RESET)
      I_CE && enable_rise && straps_taken && !is_output && state == ST_IDLE
      |=> state == ST_SEARCH)
      else $error("enable did not start clock search");
   a_loss_fallback: assert property (@(posedge I_CLK)
      disable iff (I_RESET)
      I_CE && state == ST_LOCKED && clock_lost && !is_output
      |=> state == ST_INTERNAL)
      else $error("lost clock did not fall back");
   a_sw_n_range: assert property (@(posedge I_CLK)
      disable iff (I_RESET) sw_n >= N_MIN && sw_n <= N_MAX)
      else $error("software divider out of range");
   a_strap_held: assert property (@(posedge I_CLK)
      disable iff (I_RESET) straps_taken |=> $stable(pin))
      else $error("strap changed after start-up");
   // oscillator phase restarts high on each incoming rising edge while locked
   a_align_restart: assert property (@(posedge I_CLK)
      disable iff (I_RESET) I_CE && align |=> osc)
      else $error("oscillator not restarted by incoming edge");
endmodule : swclk_select
`default_nettype wire

// ===== testbench/swclk_src.sv
// Purpose: far-side clock source on the shared sync line
// Assumes: edges land on I_CLK, as the design samples the pin there
// Notes: a released source drives the line low itself
`timescale 1ns/1ns
`default_nettype none
module swclk_src
(
   // clock and control
   input wire logic i_clk,
   input wire logic i_on,
   input wire logic [9:0] i_half,
   // shared line drive
   output logic o_sync
);
   logic [9:0] cnt;
   always_ff @(posedge i_clk)
   begin
      if (!i_on)
      begin
         cnt <= 10'h000;
         o_sync <= 1'b0;
      end
      else if (cnt >= i_half - 10'h001)
      begin
         cnt <= 10'h000;
         o_sync <= ~o_sync;
      end
      else
         cnt <= cnt + 10'h001;
   end
endmodule : swclk_src
`default_nettype wire

// ===== testbench/switching_clock_source_select_bench.sv
// Purpose: self-checking bench for the switching clock selector
// Assumes: LOSS_LIMIT shortened to 300, above the slowest test period
// Notes: one source drives the line at a time, never the device too
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module switching_clock_source_select_bench
   import swclk_pkg::*;
;
   logic I_CLK = 0, I_RESET = 1, I_ENABLE = 0, I_STARTUP_DONE = 0;
   logic I_WR = 0, I_RD = 0, src_on = 0, rd_d = 0;
   logic [1:0] I_MODE_STRAP = 2'h0, I_PIN_STRAP = 2'h0;
   logic [4:0] I_RES_CODE = 5'h00;
   logic [3:0] I_ADDR = 4'h0;
   logic [15:0] I_WDATA = 16'h0000, f;
   logic [9:0] src_half = 10'h03c;
   wire logic I_SYNC_IN, O_SYNC_OUT, O_SYNC_OE, O_SW_CLK, O_LOCKED, src;
   wire logic [15:0] O_RDATA;
   int errors = 0, tests_run = 0, eo, es;
   int unsigned exp_lo[$], exp_hi[$], n;
   assign I_SYNC_IN = O_SYNC_OE ? O_SYNC_OUT : src;
   always #10 I_CLK = ~I_CLK;
   swclk_select #(.LOSS_LIMIT(300)) DUT (.I_CLK(I_CLK), .I_RESET(I_RESET),
      .I_CE(1'b1), .I_MODE_STRAP(I_MODE_STRAP), .I_PIN_STRAP(I_PIN_STRAP),
      .I_RES_CODE(I_RES_CODE), .I_STARTUP_DONE(I_STARTUP_DONE),
      .I_ENABLE(I_ENABLE), .I_SYNC_IN(I_SYNC_IN), .O_SYNC_OUT(O_SYNC_OUT),
      .O_SYNC_OE(O_SYNC_OE), .O_SW_CLK(O_SW_CLK), .O_LOCKED(O_LOCKED),
      .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
      .O_RDATA(O_RDATA));
   swclk_src PEER (.i_clk(I_CLK), .i_on(src_on), .i_half(src_half),
      .o_sync(src));
   // read data are checked in the cycle after the strobe; O_RDATA holds them until the next read
   always @(posedge I_CLK) rd_d <= I_RD;
   always @(negedge I_CLK)
   begin : watch
      int unsigned lo, hi;
      if (rd_d === 1'b1)
      begin
         lo = exp_lo.pop_front();
         hi = exp_hi.pop_front();
         `CHK(O_RDATA >= lo && O_RDATA <= hi, 1'b1)
      end
   end
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input int unsigned lo, hi);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      exp_lo.push_back(lo);
      exp_hi.push_back(hi);
      @(posedge I_CLK);
      I_RD <= 1'b0;
      repeat (2) @(posedge I_CLK);
   endtask : rd
   task start(input logic [1:0] m, p, input logic [4:0] r);
      @(posedge I_CLK);
      I_RESET <= 1'b1;
      I_ENABLE <= 1'b0;
      I_STARTUP_DONE <= 1'b0;
      I_MODE_STRAP <= m;
      I_PIN_STRAP <= p;
      I_RES_CODE <= r;
      repeat (10) @(posedge I_CLK);
      `CHK({O_SYNC_OE, O_LOCKED, O_SW_CLK}, 3'h0)
      I_RESET <= 1'b0;
      @(posedge I_CLK);
      I_STARTUP_DONE <= 1'b1;
      repeat (3) @(posedge I_CLK);
   endtask : start
   task wait_lock(input logic v);
      int i;
      for (i = 0; i < 1000 && O_LOCKED !== v; i++) @(negedge I_CLK);
      `CHK(O_LOCKED, v)
      if (O_LOCKED !== v) give_verdict();
   endtask : wait_lock
   // rising edges of sync out and switching clock over 1200 cycles
   task edges;
      logic po, ps;
      eo = 0;
      es = 0;
      po = O_SYNC_OUT;
      ps = O_SW_CLK;
      repeat (1200) @(negedge I_CLK)
      begin
         eo += int'(O_SYNC_OUT && !po);
         es += int'(O_SW_CLK && !ps);
         po = O_SYNC_OUT;
         ps = O_SW_CLK;
      end
   endtask : edges
   initial
   begin
      repeat (100000) @(posedge I_CLK);
      errors++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(31069));
      start(2'h2, 2'h1, 5'h00);
      I_ENABLE <= 1'b1;
      edges();
      `CHK(O_SYNC_OE, 1'b1)
      `CHK(eo >= 9 && eo <= 11, 1'b1)
      `CHK(O_LOCKED, 1'b0)
      rd(REG_RDBK, N_400K, N_400K);
      $display("test output mode done");
      start(2'h0, 2'h1, 5'h00);
      src_half <= 10'h03c;
      src_on <= 1'b1;
      repeat (20) @(posedge I_CLK);
      I_ENABLE <= 1'b1;
      wait_lock(1'b1);
      `CHK(O_SYNC_OE, 1'b0)
      edges();
      `CHK(es >= 9 && es <= 11, 1'b1)
      src_on <= 1'b0;
      wait_lock(1'b0);
      edges();
      `CHK(es >= 9 && es <= 11, 1'b1)
      rd(REG_RDBK, 19, 21);
      I_ENABLE <= 1'b0;
      src_half <= 10'h019;
      src_on <= 1'b1;
      repeat (20) @(posedge I_CLK);
      I_ENABLE <= 1'b1;
      wait_lock(1'b1);
      src_on <= 1'b0;
      $display("test input mode done");
      for (int p = 0; p < 4; p++)
      begin
         start(2'h1, 2'(p), 5'h10);
         I_ENABLE <= 1'b1;
         repeat (400) @(posedge I_CLK);
         `CHK(O_LOCKED, 1'b0)
         I_PIN_STRAP <= 2'(p + 1);
         n = (p == 0) ? N_200K : (p == 1) ? N_400K : N_1M;
         rd(REG_RDBK, n, n);
      end
      // no ramp timing mode is modelled, so auto-detect may run
      start(2'h1, 2'h1, 5'h00);
      src_on <= 1'b1;
      repeat (20) @(posedge I_CLK);
      I_ENABLE <= 1'b1;
      wait_lock(1'b1);
      src_on <= 1'b0;
      $display("test auto mode done");
      start(2'h0, 2'h1, 5'h00);
      wr(REG_CTRL, 16'h0001);
      for (int k = 0; k < 11; k++)
      begin
         f = (k == 0) ? 16'd810 : (k == 1) ? 16'd1000 : (k == 2) ? 16'd200
            : 16'(200 + $urandom % 801);
         n = (16000 / f + 1) / 2;
         wr(REG_FREQ, f);
         rd(REG_FREQ, n, n);
         rd(REG_RDBK, n, n);
      end
      wr(4'hf, 16'h0123);
      rd(4'hf, 0, 0);
      rd(REG_FREQ, n, n);
      $display("test software frequency done");
      give_verdict();
   end
endmodule : switching_clock_source_select_bench
`default_nettype wire
